// *** include/iscs_pkg.sv ***
// Package: register map, field layout, sequencer timing and state types of the sensor control block
package iscs_pkg;

  // ----------------------------------------------------------------
  // Register addresses (top four bits of each written word)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_AMP = 4'h0;
  localparam logic [3:0] ADDR_COARSE = 4'h1;
  localparam logic [3:0] ADDR_FINE = 4'h2;
  localparam logic [3:0] ADDR_CONV = 4'h3;
  localparam logic [3:0] ADDR_PIXCNT = 4'h4;
  localparam logic [3:0] ADDR_LINECNT = 4'h5;
  localparam logic [3:0] ADDR_INTTIME = 4'h6;
  localparam logic [3:0] ADDR_ROWPTR = 4'h7;
  localparam logic [3:0] ADDR_TIMING = 4'h8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GAIN_LSB = 0;
  localparam int GAIN_MSB = 3;
  localparam int UNITY_BIT = 4;
  localparam int DUAL_BIT = 5;
  localparam int STANDBY_BIT = 6;
  localparam int DRIVE_BIT = 0;
  localparam int CURVE_BIT = 1;
  localparam int POLARITY_BIT = 2;
  localparam int SHUT_DIV_LSB = 0;
  localparam int SHUT_DIV_MSB = 1;
  localparam int ROW_DIV_LSB = 2;
  localparam int ROW_DIV_MSB = 3;
  localparam int WORD_ADDR_MSB = 15;
  localparam int WORD_ADDR_LSB = 12;

  // ----------------------------------------------------------------
  // Reset values: every configuration register clears to zero
  // ----------------------------------------------------------------
  localparam logic [6:0] AMP_RESET = 7'h00;
  localparam logic [6:0] OFFSET_RESET = 7'h00;
  localparam logic [2:0] CONV_RESET = 3'h0;
  localparam logic [11:0] COUNT_RESET = 12'h000;
  localparam logic [10:0] ROWPTR_RESET = 11'h000;
  localparam logic [3:0] TIMING_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Sequencer timing: dividers in system-clock cycles, blanking and phase lengths in ticks, two-wire ack bit count
  // ----------------------------------------------------------------
  localparam logic [8:0] SHUT_BASE_DIV = 9'h020;
  localparam logic [10:0] ROW_BASE_DIV = 11'h004;
  localparam logic [10:0] ROW_BLANK_MULT = 11'h023;
  localparam logic [2:0] CORE_RESET_TICKS = 3'h4;
  localparam logic [2:0] CORE_READY_TICKS = 3'h2;
  localparam logic [3:0] TWI_ACK_BIT = 4'h8;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SH_IDLE = 3'b000,
    SH_START = 3'b001,
    SH_RESET = 3'b010,
    SH_INTEG = 3'b011,
    SH_WAIT = 3'b100,
    SH_STOP = 3'b101,
    SH_READY = 3'b110
  } iscs_shut_type;

  typedef enum logic [1:0] {
    RW_IDLE = 2'b00,
    RW_HOLD = 2'b01,
    RW_BLANK = 2'b10,
    RW_PIXELS = 2'b11
  } iscs_row_type;

  typedef struct packed {
    // Configuration registers
    logic [6:0] amp;
    logic [6:0] coarse;
    logic [6:0] fine;
    logic [2:0] conv;
    logic [11:0] pixCount;
    logic [11:0] lineCount;
    logic [11:0] intTime;
    logic [10:0] readRow;
    logic [3:0] timing;
    // Applied amplifier outputs
    logic [3:0] gainOut;
    logic unityOut;
    logic dualOut;
    logic secondStandby;
    logic ampEnable;
    // Input history for edge detection
    logic parWrPrev;
    logic sClkPrev;
    logic sDataPrev;
    logic sEnNPrev;
    logic startPrev;
    logic stopPrev;
    logic frameStartPrev;
    logic lineClkPrev;
    // Three-wire and two-wire receivers
    logic [15:0] spiShift;
    logic [7:0] twiShift;
    logic [3:0] twiBit;
    logic [1:0] twiByte;
    logic [7:0] twiHigh;
    logic twiActive;
    logic twiAck;
    // Shutter sequencer
    iscs_shut_type shut;
    logic [8:0] shutDiv;
    logic [2:0] phaseCnt;
    logic [11:0] intCnt;
    logic timeOut;
    logic coreReset;
    logic coreReadable;
    // Row readout sequencer
    iscs_row_type row;
    logic [10:0] blankCnt;
    logic [11:0] pixCnt;
    logic [11:0] lineCnt;
    logic [10:0] rowPtr;
    logic pixelValid;
    logic lastLine;
    // Two-entry output buffer
    logic [9:0] buf0;
    logic [9:0] buf1;
    logic [1:0] bufCnt;
    logic outValid;
  } iscs_state_type;

endpackage

// *** logic/iscs_sequencer.sv ***
// Top module: configuration ports, output stage settings, shutter and row readout sequencers
`timescale 1ns/10ps
module iscs_sequencer (
  input wire logic clk,
  input wire logic reset,
  input wire logic interfaceSelect,
  input wire logic serialWidthStrap,
  input wire logic [15:0] parallelData,
  input wire logic parallelWrite,
  input wire logic serialClk,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  input wire logic serialEnableN,
  input wire logic shutterStart,
  input wire logic shutterStop,
  input wire logic frameStart,
  input wire logic lineClock,
  input wire logic [9:0] converterIn,
  output logic [9:0] converterData,
  output logic converterOutputDrive,
  output logic converterValid,
  input wire logic converterReady,
  output logic [3:0] gainSetting,
  output logic unityFeedback,
  output logic dualOutput,
  output logic secondPathStandby,
  output logic ampEnable,
  output logic [6:0] blackOffsetCoarse,
  output logic [6:0] blackOffsetFine,
  output logic timeOut,
  output logic coreReset,
  output logic coreReadable,
  output logic pixelValid,
  output logic lastLine,
  output logic [10:0] readRowPointer
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Shutter tick length: 32, 64, 128 or 256 system cycles
  function automatic logic [8:0] shutTicks(input logic [1:0] code);
    shutTicks = iscs_pkg::SHUT_BASE_DIV << code;
  endfunction

  // Row blanking length: 35 row ticks of 4, 8, 16 or 32 cycles
  function automatic logic [10:0] rowBlank(input logic [1:0] code);
    logic [10:0] tick;
    tick = iscs_pkg::ROW_BASE_DIV << code;
    rowBlank = 11'(iscs_pkg::ROW_BLANK_MULT * tick);
  endfunction

  // Piecewise compressive law: steep at the dark end, flat at the bright end
  function automatic logic [9:0] compress(input logic [9:0] x);
    if (x < 10'h100) begin
      compress = 10'(x << 1);
    end else if (x < 10'h200) begin
      compress = 10'(10'h200 + (x - 10'h100));
    end else begin
      compress = 10'(10'h300 + ((x - 10'h200) >> 1));
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  iscs_pkg::iscs_state_type s_reg;
  iscs_pkg::iscs_state_type s_next;

  // Next-state logic for the whole block
  always_comb begin
    logic wrStb;
    logic [15:0] wrWord;
    logic sclRise;
    logic sclFall;
    logic twiStart;
    logic twiStop;
    logic shutTick;
    logic push;
    logic pop;
    logic [9:0] pixWord;
    wrStb = 1'b0;
    wrWord = 16'h0000;
    s_next = s_reg;

    // Edge history of the strobes and serial pins
    s_next.parWrPrev = parallelWrite;
    s_next.sClkPrev = serialClk;
    s_next.sDataPrev = serialDataIn;
    s_next.sEnNPrev = serialEnableN;
    s_next.startPrev = shutterStart;
    s_next.stopPrev = shutterStop;
    s_next.frameStartPrev = frameStart;
    s_next.lineClkPrev = lineClock;
    sclRise = serialClk && !s_reg.sClkPrev;
    sclFall = !serialClk && s_reg.sClkPrev;
    twiStart = serialClk && s_reg.sClkPrev && s_reg.sDataPrev && !serialDataIn;
    twiStop = serialClk && s_reg.sClkPrev && !s_reg.sDataPrev && serialDataIn;

    // ----------------------------------------------------------------
    // Configuration ports, chosen by the straps
    // ----------------------------------------------------------------
    if (interfaceSelect) begin
      // Parallel: the word is taken in the cycle the strobe rises
      if (parallelWrite && !s_reg.parWrPrev) begin
        wrStb = 1'b1;
        wrWord = parallelData;
      end
    end else if (serialWidthStrap) begin
      // Three-wire: MSB first on clock rise, loaded when enable goes low
      if (sclRise) begin
        s_next.spiShift = {s_reg.spiShift[14:0], serialDataIn};
      end
      if (!serialEnableN && s_reg.sEnNPrev) begin
        wrStb = 1'b1;
        wrWord = s_reg.spiShift;
      end
    end else begin
      // Two-wire: first byte is addressing plus direction bit, which is
      // never looked at since this port only accepts writes
      if (twiStart) begin
        s_next.twiActive = 1'b1;
        s_next.twiBit = 4'h0;
        s_next.twiByte = 2'h0;
        s_next.twiAck = 1'b0;
      end else if (twiStop) begin
        s_next.twiActive = 1'b0;
        s_next.twiAck = 1'b0;
      end else if (s_reg.twiActive) begin
        if (sclRise && s_reg.twiBit < iscs_pkg::TWI_ACK_BIT) begin
          s_next.twiShift = {s_reg.twiShift[6:0], serialDataIn};
          s_next.twiBit = s_reg.twiBit + 4'h1;
        end
        if (sclFall && s_reg.twiAck) begin
          // Ninth clock done: release the line and commit the byte
          s_next.twiAck = 1'b0;
          s_next.twiBit = 4'h0;
          if (s_reg.twiByte == 2'h1) begin
            s_next.twiHigh = s_reg.twiShift;
            s_next.twiByte = 2'h2;
          end else if (s_reg.twiByte == 2'h2) begin
            wrStb = 1'b1;
            wrWord = {s_reg.twiHigh, s_reg.twiShift};
            s_next.twiByte = 2'h1;
          end else begin
            s_next.twiByte = 2'h1;
          end
        end else if (sclFall && s_reg.twiBit == iscs_pkg::TWI_ACK_BIT) begin
          s_next.twiAck = 1'b1;
        end
      end
    end
    if (!(!interfaceSelect && !serialWidthStrap)) begin
      s_next.twiActive = 1'b0;
      s_next.twiAck = 1'b0;
    end

    // ----------------------------------------------------------------
    // Register decode: one register per word
    // ----------------------------------------------------------------
    if (wrStb) begin
      if (wrWord[15:12] == iscs_pkg::ADDR_AMP) begin
        s_next.amp = wrWord[6:0];
      end else if (wrWord[15:12] == iscs_pkg::ADDR_COARSE) begin
        s_next.coarse = wrWord[6:0];
      end else if (wrWord[15:12] == iscs_pkg::ADDR_FINE) begin
        s_next.fine = wrWord[6:0];
      end else if (wrWord[15:12] == iscs_pkg::ADDR_CONV) begin
        s_next.conv = wrWord[2:0];
      end else if (wrWord[15:12] == iscs_pkg::ADDR_PIXCNT) begin
        s_next.pixCount = wrWord[11:0];
      end else if (wrWord[15:12] == iscs_pkg::ADDR_LINECNT) begin
        s_next.lineCount = wrWord[11:0];
      end else if (wrWord[15:12] == iscs_pkg::ADDR_INTTIME) begin
        s_next.intTime = wrWord[11:0];
      end else if (wrWord[15:12] == iscs_pkg::ADDR_ROWPTR) begin
        s_next.readRow = wrWord[10:0];
      end else if (wrWord[15:12] == iscs_pkg::ADDR_TIMING) begin
        s_next.timing = wrWord[3:0];
      end
    end

    // Output amplifier settings as applied to the analog stage
    s_next.unityOut = s_next.amp[iscs_pkg::UNITY_BIT];
    s_next.gainOut = s_next.unityOut ? 4'h0 : s_next.amp[iscs_pkg::GAIN_MSB:iscs_pkg::GAIN_LSB];
    s_next.ampEnable = s_next.amp[iscs_pkg::STANDBY_BIT];
    s_next.dualOut = s_next.amp[iscs_pkg::DUAL_BIT] && s_next.ampEnable;
    s_next.secondStandby = !s_next.dualOut;

    // ----------------------------------------------------------------
    // Shutter sequencer on the granulated tick
    // ----------------------------------------------------------------
    shutTick = (s_reg.shutDiv == shutTicks(s_reg.timing[iscs_pkg::SHUT_DIV_MSB:iscs_pkg::SHUT_DIV_LSB]) - 9'h001);
    s_next.shutDiv = shutTick ? 9'h000 : s_reg.shutDiv + 9'h001;
    if (shutTick) begin
      s_next.timeOut = 1'b0;
    end
    if (shutterStart) begin
      s_next.shut = iscs_pkg::SH_START;
      s_next.coreReset = 1'b0;
      s_next.coreReadable = 1'b0;
    end else if (shutterStop && s_reg.shut != iscs_pkg::SH_IDLE && s_reg.shut != iscs_pkg::SH_READY) begin
      s_next.shut = iscs_pkg::SH_STOP;
      s_next.coreReset = 1'b0;
    end else begin
      case (s_reg.shut)
        iscs_pkg::SH_START: begin
          // Restart the divider so the first tick follows the falling strobe
          s_next.shut = iscs_pkg::SH_RESET;
          s_next.shutDiv = 9'h000;
          s_next.phaseCnt = 3'h0;
          s_next.intCnt = 12'h000;
          s_next.coreReset = 1'b1;
        end
        iscs_pkg::SH_RESET: begin
          if (shutTick) begin
            s_next.intCnt = s_reg.intCnt + 12'h001;
            s_next.phaseCnt = s_reg.phaseCnt + 3'h1;
            if (s_reg.phaseCnt == iscs_pkg::CORE_RESET_TICKS - 3'h1) begin
              s_next.shut = iscs_pkg::SH_INTEG;
              s_next.coreReset = 1'b0;
            end
          end
        end
        iscs_pkg::SH_INTEG: begin
          if (shutTick) begin
            if (s_reg.intCnt == s_reg.intTime) begin
              s_next.timeOut = 1'b1;
              s_next.shut = iscs_pkg::SH_WAIT;
            end else begin
              s_next.intCnt = s_reg.intCnt + 12'h001;
            end
          end
        end
        iscs_pkg::SH_STOP: begin
          s_next.shut = iscs_pkg::SH_READY;
          s_next.shutDiv = 9'h000;
          s_next.phaseCnt = 3'h0;
        end
        iscs_pkg::SH_READY: begin
          if (shutTick) begin
            s_next.phaseCnt = s_reg.phaseCnt + 3'h1;
            if (s_reg.phaseCnt == iscs_pkg::CORE_READY_TICKS - 3'h1) begin
              s_next.shut = iscs_pkg::SH_IDLE;
              s_next.coreReadable = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Row readout sequencer
    // ----------------------------------------------------------------
    pixWord = s_reg.conv[iscs_pkg::CURVE_BIT] ? converterIn : compress(converterIn);
    pixWord = s_reg.conv[iscs_pkg::POLARITY_BIT] ? pixWord : ~pixWord;
    pop = s_reg.outValid && converterReady;
    // A full buffer stalls the pixel counter instead of dropping words
    push = (s_reg.row == iscs_pkg::RW_PIXELS) && (s_reg.bufCnt != 2'h2);

    if (frameStart && !s_reg.frameStartPrev) begin
      s_next.rowPtr = s_reg.readRow;
      s_next.lineCnt = 12'h000;
      s_next.lastLine = 1'b0;
    end
    if (lineClock) begin
      // Held while the line clock is high, whatever phase it was in
      s_next.row = iscs_pkg::RW_HOLD;
      s_next.pixelValid = 1'b0;
      if (!s_reg.lineClkPrev) begin
        s_next.lineCnt = s_reg.lineCnt + 12'h001;
        s_next.rowPtr = s_reg.rowPtr + 11'h001;
      end
    end else begin
      case (s_reg.row)
        iscs_pkg::RW_HOLD: begin
          s_next.row = iscs_pkg::RW_BLANK;
          s_next.blankCnt = 11'h000;
          s_next.lastLine = (s_reg.lineCnt == s_reg.lineCount);
        end
        iscs_pkg::RW_BLANK: begin
          s_next.blankCnt = s_reg.blankCnt + 11'h001;
          if (s_reg.blankCnt == rowBlank(s_reg.timing[iscs_pkg::ROW_DIV_MSB:iscs_pkg::ROW_DIV_LSB]) - 11'h001) begin
            s_next.row = iscs_pkg::RW_PIXELS;
            s_next.pixelValid = 1'b1;
            s_next.pixCnt = 12'h000;
          end
        end
        iscs_pkg::RW_PIXELS: begin
          if (push) begin
            s_next.pixCnt = s_reg.pixCnt + 12'h001;
            if (s_reg.pixCnt == s_reg.pixCount) begin
              s_next.pixelValid = 1'b0;
              s_next.row = iscs_pkg::RW_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Two-entry buffer between converter and data pins
    case ({push, pop})
      2'b10: begin
        if (s_reg.bufCnt == 2'h0) begin
          s_next.buf0 = pixWord;
        end else begin
          s_next.buf1 = pixWord;
        end
        s_next.bufCnt = s_reg.bufCnt + 2'h1;
      end
      2'b01: begin
        s_next.buf0 = s_reg.buf1;
        s_next.bufCnt = s_reg.bufCnt - 2'h1;
      end
      2'b11: begin
        if (s_reg.bufCnt == 2'h1) begin
          s_next.buf0 = pixWord;
        end else begin
          s_next.buf0 = s_reg.buf1;
          s_next.buf1 = pixWord;
        end
      end
      default: begin
      end
    endcase
    s_next.outValid = (s_next.bufCnt != 2'h0);
  end

  // State register; reset clears every configuration field to zero
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from the state register except serial data out, tied low
  // ----------------------------------------------------------------
  assign serialDataOut = 1'b0;
  assign serialDataOe = s_reg.twiAck;
  assign converterData = s_reg.buf0;
  assign converterOutputDrive = s_reg.conv[iscs_pkg::DRIVE_BIT];
  assign converterValid = s_reg.outValid;
  assign gainSetting = s_reg.gainOut;
  assign unityFeedback = s_reg.unityOut;
  assign dualOutput = s_reg.dualOut;
  assign secondPathStandby = s_reg.secondStandby;
  assign ampEnable = s_reg.ampEnable;
  // Fine code is passed through; its mid-scale point is software's to set
  assign blackOffsetCoarse = s_reg.coarse;
  assign blackOffsetFine = s_reg.fine;
  assign timeOut = s_reg.timeOut;
  assign coreReset = s_reg.coreReset;
  assign coreReadable = s_reg.coreReadable;
  assign pixelValid = s_reg.pixelValid;
  assign lastLine = s_reg.lastLine;
  assign readRowPointer = s_reg.rowPtr;

endmodule

// *** dv/iscs_sink.sv ***
// Partner model: converter data sink that stalls, then accepts every other cycle
`timescale 1ns/10ps
module iscs_sink (
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] converterData,
  input wire logic converterValid,
  output logic converterReady,
  output logic [7:0] wordCount,
  output logic [9:0] lastWord
);
  logic [4:0] stallCnt;
  logic toggle;
  // Long stall first so the two-entry buffer fills and pushes back on the readout
  always_ff @(posedge clk) begin
    if (reset) begin
      stallCnt <= 5'h00;
      toggle <= 1'b0;
      wordCount <= 8'h00;
      lastWord <= 10'h000;
    end else begin
      toggle <= ~toggle;
      if (converterValid && stallCnt != 5'h1F) stallCnt <= stallCnt + 5'h01;
      if (converterValid && converterReady) begin
        wordCount <= wordCount + 8'h01;
        lastWord <= converterData;
      end
    end
  end
  // Never ready during the stall, half rate after it
  assign converterReady = (stallCnt == 5'h1F) && toggle;
endmodule

// *** dv/iscs_sequencer_chk.sv ***
// Checker: timing and output relations at the sensor control block ports
`timescale 1ns/10ps
module iscs_sequencer_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic shutterStart,
  input wire logic lineClock,
  input wire logic [3:0] gainSetting,
  input wire logic unityFeedback,
  input wire logic dualOutput,
  input wire logic secondPathStandby,
  input wire logic ampEnable,
  input wire logic [6:0] blackOffsetCoarse,
  input wire logic timeOut,
  input wire logic coreReset,
  input wire logic pixelValid,
  input wire logic [10:0] readRowPointer
);
  logic [10:0] toLen;
  logic [10:0] crLen;
  logic [10:0] blankLen;
  // Pulse and gap lengths in system cycles; too long for a repetition operator
  always_ff @(posedge clk) begin
    toLen <= timeOut ? toLen + 11'h001 : 11'h000;
    crLen <= coreReset ? crLen + 11'h001 : 11'h000;
    blankLen <= (lineClock || pixelValid) ? 11'h000 : blankLen + 11'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_unity_gain: assert property (unityFeedback |-> gainSetting == 4'h0)
    else $error("gain applied under unity feedback");
  a_path_standby: assert property (!$past(reset) |-> secondPathStandby == !dualOutput)
    else $error("second path standby disagrees with dual output");
  a_dual_amp: assert property (dualOutput |-> ampEnable)
    else $error("dual output while amplifier in standby");
  a_reset_clear: assert property (disable iff (1'b0) reset |=> gainSetting == 4'h0 && !ampEnable
    && blackOffsetCoarse == 7'h00 && readRowPointer == 11'h000 && !timeOut)
    else $error("outputs not cleared by reset");
  a_timeout_width: assert property ($fell(timeOut) |-> toLen inside {32, 64, 128, 256})
    else $error("time-out pulse not one shutter tick");
  a_core_reset: assert property ($fell(coreReset) |-> crLen inside {128, 256, 512, 1024})
    else $error("core reset not four shutter ticks");
  a_start_suspend: assert property (shutterStart |=> !coreReset)
    else $error("sequencer ran while start strobe high");
  a_blank_time: assert property ($rose(pixelValid) |->
    blankLen inside {[139:142], [279:282], [559:562], [1119:1122]})
    else $error("row blanking length wrong");
  a_line_suspend: assert property (lineClock |=> !pixelValid)
    else $error("pixels read while line clock high");
  cover property ($fell(timeOut));
  cover property ($rose(pixelValid));
  cover property ($fell(coreReset));
endmodule
bind iscs_sequencer iscs_sequencer_chk i_iscs_sequencer_chk (.clk, .reset, .shutterStart, .lineClock,
  .gainSetting, .unityFeedback, .dualOutput, .secondPathStandby, .ampEnable, .blackOffsetCoarse, .timeOut,
  .coreReset, .pixelValid, .readRowPointer);

// *** dv/iscs_sequencer_tb.sv ***
// Testbench: three configuration ports, shutter timing and row readout
`timescale 1ns/10ps
module iscs_sequencer_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic interfaceSelect = 1'b1;
  logic serialWidthStrap = 1'b0;
  logic [15:0] parallelData = 16'h0000;
  logic parallelWrite = 1'b0;
  logic serialClk = 1'b0;
  logic sdaDrive = 1'b1;
  logic serialEnableN = 1'b1;
  logic shutterStart = 1'b0;
  logic shutterStop = 1'b0;
  logic frameStart = 1'b0;
  logic lineClock = 1'b0;
  logic serialDataOut, serialDataOe, converterOutputDrive, converterValid, converterReady, sdaSeen;
  logic unityFeedback, dualOutput, secondPathStandby, ampEnable, timeOut, coreReset, coreReadable;
  logic pixelValid, lastLine;
  logic [9:0] converterData, lastWord;
  logic [3:0] gainSetting;
  logic [6:0] blackOffsetCoarse, blackOffsetFine;
  logic [10:0] readRowPointer;
  logic [7:0] wordCount;
  int errCount = 0;
  int cmpCount = 0;
  int cycles = 0;
  int n;
  // Open-drain data line with pull-up: low when the device acknowledges
  wire logic sda = serialDataOe ? serialDataOut : sdaDrive;
  // Register word, expected {gain, unity, dual, standby2, enable, coarse, fine, drive}
  localparam logic [38:0] ROWS [10] = '{
    {16'h0045, 4'h5, 4'h3, 15'h0000}, {16'h0055, 4'h0, 4'hB, 15'h0000},
    {16'h0075, 4'h0, 4'hD, 15'h0000}, {16'h0065, 4'h5, 4'h5, 15'h0000},
    {16'h0025, 4'h5, 4'h2, 15'h0000}, {16'h107F, 4'h5, 4'h2, 15'h7F00},
    {16'h2040, 4'h5, 4'h2, 15'h7F80}, {16'h3001, 4'h5, 4'h2, 15'h7F81},
    {16'h9ABC, 4'h5, 4'h2, 15'h7F81}, {16'h3006, 4'h5, 4'h2, 15'h7F80}};
  localparam logic [7:0] TWI [3] = '{8'h21, 8'h20, 8'h2A};
  iscs_sequencer i_iscs_sequencer (.clk, .reset, .interfaceSelect, .serialWidthStrap, .parallelData,
    .parallelWrite, .serialClk, .serialDataIn(sda), .serialDataOut, .serialDataOe, .serialEnableN,
    .shutterStart, .shutterStop, .frameStart, .lineClock, .converterIn(10'h155), .converterData,
    .converterOutputDrive, .converterValid, .converterReady, .gainSetting, .unityFeedback, .dualOutput,
    .secondPathStandby, .ampEnable, .blackOffsetCoarse, .blackOffsetFine, .timeOut, .coreReset,
    .coreReadable, .pixelValid, .lastLine, .readRowPointer);
  iscs_sink i_iscs_sink (.clk, .reset, .converterData, .converterValid, .converterReady, .wordCount, .lastWord);
  // Clock, and a cycle ceiling that cuts a hang short
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      tallyAndFinish();
    end
  end
  task automatic tallyAndFinish();
    if (errCount == 0 && cmpCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  function automatic logic [22:0] ampVec();
    return {gainSetting, unityFeedback, dualOutput, secondPathStandby, ampEnable, blackOffsetCoarse,
      blackOffsetFine, converterOutputDrive};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Bounded wait; reads at the edge, so counts run one cycle late
  task automatic waitFor(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic pWrite(input logic [15:0] w);
    parallelData <= w;
    parallelWrite <= 1'b1;
    cyc(2);
    parallelWrite <= 1'b0;
    cyc(3);
  endtask
  // Serial clock held four system cycles per level, well below the sampling limit
  task automatic sclBit(input logic v);
    sdaDrive <= v;
    cyc(3);
    serialClk <= 1'b1;
    cyc(4);
    sdaSeen = sda;
    serialClk <= 1'b0;
    cyc(1);
  endtask
  task automatic twiByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) sclBit(b[i]);
    sclBit(1'b1);
    chk("twi_ack", 32'h0, 32'(sdaSeen));
  endtask
  // Line strobe, then the whole row: pixel-valid up and back down
  task automatic readRow(input logic [9:0] word, input logic last, input logic [7:0] total);
    lineClock <= 1'b1;
    cyc(1);
    lineClock <= 1'b0;
    waitFor(pixelValid, 1'b1, 1300, n);
    chk("blank", 32'h1, 32'(n >= 276 && n <= 288));
    chk("last_line", 32'(last), 32'(lastLine));
    waitFor(pixelValid, 1'b0, 300, n);
    cyc(40);
    chk("words", 32'(total), 32'(wordCount));
    chk("word", 32'(word), 32'(lastWord));
  endtask
  initial begin
    cyc(12);
    reset <= 1'b0;
    cyc(3);
    chk("rst_amp", 32'h0001_0000, 32'(ampVec()));
    chk("rst_seq", 32'h0, 32'({timeOut, coreReadable, pixelValid, lastLine, readRowPointer, converterValid}));
    foreach (ROWS[i]) begin
      pWrite(ROWS[i][38:23]);
      chk("amp_row", 32'(ROWS[i][22:0]), 32'(ampVec()));
    end
    interfaceSelect <= 1'b0;
    serialWidthStrap <= 1'b1;
    for (int i = 15; i >= 0; i--) sclBit(1'(16'h1033 >> i));
    serialEnableN <= 1'b0;
    cyc(4);
    serialEnableN <= 1'b1;
    cyc(4);
    pWrite(16'h1011);
    chk("coarse_3w", 32'h33, 32'(blackOffsetCoarse));
    serialWidthStrap <= 1'b0;
    sdaDrive <= 1'b1;
    serialClk <= 1'b1;
    cyc(4);
    sdaDrive <= 1'b0;
    cyc(4);
    serialClk <= 1'b0;
    cyc(2);
    foreach (TWI[i]) twiByte(TWI[i]);
    sdaDrive <= 1'b0;
    cyc(4);
    serialClk <= 1'b1;
    cyc(4);
    sdaDrive <= 1'b1;
    cyc(4);
    chk("fine_2w", 32'h2A, 32'(blackOffsetFine));
    interfaceSelect <= 1'b1;
    pWrite(16'h8004);
    pWrite(16'h600A);
    pWrite(16'h7155);
    pWrite(16'h4003);
    pWrite(16'h5001);
    pWrite(16'h3007);
    shutterStart <= 1'b1;
    cyc(2);
    shutterStart <= 1'b0;
    waitFor(timeOut, 1'b1, 1000, n);
    chk("int_time", 32'h1, 32'(n >= 280 && n <= 360));
    waitFor(timeOut, 1'b0, 300, n);
    shutterStop <= 1'b1;
    cyc(2);
    shutterStop <= 1'b0;
    waitFor(coreReadable, 1'b1, 200, n);
    chk("ready_time", 32'h1, 32'(n >= 56 && n <= 72));
    frameStart <= 1'b1;
    cyc(3);
    frameStart <= 1'b0;
    cyc(3);
    chk("row_ptr", 32'h155, 32'(readRowPointer));
    readRow(10'h155, 1'b1, 8'h04);
    pWrite(16'h3001);
    readRow(10'h1AA, 1'b0, 8'h08);
    tallyAndFinish();
  end
endmodule
